// *** core/nvm_byte_access.sv ***
// Summary of operation
// - ten-bit address indexes 1024 bytes linearly
// - upper six address bits read zero
// - address not reset; software loads it
// - data register sources writes, holds reads
// - ready irq while enabled and idle
// - arm bit self-clears after four cycles
// - strobe without arm is ignored
// - strobe within arm window starts write
// - write strobe reads busy, hardware clears
// - write start stalls cpu two cycles
// - read strobe loads data immediately
// - read stalls cpu four cycles
// - busy blocks reads and address changes
// - no write start during flash self-programming
// - write lasts 8448 ticks of 1 MHz
// - upper four control bits read zero
// - reset does not abort running write
// - registers sit in i/o space
`timescale 1ns/100ps
`default_nettype none

module nvm_byte_access #(
   parameter int unsigned DEPTH        = nvm_byte_pkg::NVM_DEPTH,
   parameter int unsigned OSC_DIVIDE   = nvm_byte_pkg::OSC_DIV,
   parameter int unsigned WRITE_CYCLES = nvm_byte_pkg::WRITE_OSC_CYCLES
) (
   input  wire logic                               I_CLK_SYS,
   input  wire logic                               I_SYS_RST,
   input  wire logic [nvm_byte_pkg::IO_ADDR_W-1:0] I_IO_ADDR,
   input  wire logic                               I_IO_WR,
   input  wire logic                               I_IO_RD,
   input  wire logic [nvm_byte_pkg::DATA_W-1:0]    I_IO_WDATA,
   input  wire logic                               I_GLOBAL_IRQ_EN,
   input  wire logic                               I_SELF_PROG_ENABLE,
   output logic      [nvm_byte_pkg::DATA_W-1:0]    O_IO_RDATA,
   output logic                                    O_CPU_HALT,
   output logic                                    O_READY_IRQ
);
   import nvm_byte_pkg::*;

   //==========================================================
   // state
   //==========================================================
   typedef struct packed {
      logic [ADDR_W-1:0] addr;        // nvm_address, never reset
      logic [7:0]        data;        // nvm_data_byte
      logic              ready_ie;    // ready_irq_enable
      logic [2:0]        arm_cnt;     // cycles left in the arming window
      logic              busy;        // write in progress, reads as write_strobe
      logic [ADDR_W-1:0] cap_addr;    // address latched at write start
      logic [7:0]        cap_data;    // byte latched at write start
      logic [DIV_W-1:0]  div_cnt;     // divider toward the 1 MHz tick
      logic [TICK_W-1:0] ticks;       // oscillator ticks spent in the write
      logic [2:0]        halt_cnt;    // stall cycles still owed
      logic              halt;        // registered stall output
      logic              irq;         // registered ready request
      logic [7:0]        rdata;       // registered read-back
   } state_s;

   state_s q;                          // current state
   state_s nxt;                        // next state

   logic [7:0] mem [DEPTH];            // the byte store itself
   logic       commit;                 // last tick of a write, store the byte
   logic [7:0] mem_rd;                 // byte at the current address

   //==========================================================
   // helpers
   //==========================================================
   // register select, used by every write and read decode
   function automatic logic io_hit(input logic [IO_ADDR_W-1:0] a,
                                   input logic [IO_ADDR_W-1:0] loc,
                                   input logic                 strobe);
      io_hit = strobe && (a == loc);
   endfunction

   // control register image as software sees it
   function automatic logic [7:0] ctrl_image(input state_s s);
      logic [7:0] v;
      v = 8'h00;
      v[BIT_READY_IE]     = s.ready_ie;
      v[BIT_WRITE_ARM]    = (s.arm_cnt != 3'h0);
      v[BIT_WRITE_STROBE] = s.busy;
      v[BIT_READ_STROBE]  = 1'b0;
      ctrl_image = v;
   endfunction

   // decoded register strobes
   logic wr_ctrl;                      // write to nvm_control
   logic wr_data;                      // write to nvm_data_byte
   logic wr_alow;                      // write to nvm_addr_low
   logic wr_ahigh;                     // write to nvm_addr_high
   logic start_wr;                     // write accepted this cycle
   logic start_rd;                     // read accepted this cycle
   logic osc_tick;                     // one-cycle 1 MHz enable

   assign wr_ctrl  = io_hit(I_IO_ADDR, IO_CONTROL, I_IO_WR);
   assign wr_data  = io_hit(I_IO_ADDR, IO_DATA_BYTE, I_IO_WR);
   assign wr_alow  = io_hit(I_IO_ADDR, IO_ADDR_LOW, I_IO_WR);
   assign wr_ahigh = io_hit(I_IO_ADDR, IO_ADDR_HIGH, I_IO_WR);
   assign osc_tick = (q.div_cnt == DIV_W'(OSC_DIVIDE - 1));

   assign mem_rd = mem[q.addr];

   // the arm bit as it stood before this write, so arm and strobe
   // written together start a write only if already armed
   // arm required
   assign start_wr = wr_ctrl && I_IO_WDATA[BIT_WRITE_STROBE] && (q.arm_cnt != 3'h0)
                     && !q.busy && !I_SELF_PROG_ENABLE;
   assign start_rd = wr_ctrl && I_IO_WDATA[BIT_READ_STROBE] && !q.busy;
   assign commit   = q.busy && osc_tick && (q.ticks == TICK_W'(WRITE_CYCLES - 1));

   //==========================================================
   // next state
   //==========================================================
   // one process computes every field; reset is folded in here
   always_comb begin
      nxt = q;

      // free-running divider, the oscillator stands for the calibrated source
      if (osc_tick) begin
         nxt.div_cnt = '0;
      end else begin
         nxt.div_cnt = q.div_cnt + DIV_W'(1);
      end

      if (q.arm_cnt != 3'h0) begin
         nxt.arm_cnt = q.arm_cnt - 3'h1;
      end

      // stall countdown
      if (q.halt_cnt != 3'h0) begin
         nxt.halt_cnt = q.halt_cnt - 3'h1;
      end

      // write timing runs on the oscillator enable only
      if (q.busy && osc_tick) begin
         if (commit) begin
            nxt.busy  = 1'b0;
            nxt.ticks = '0;
         end else begin
            nxt.ticks = q.ticks + TICK_W'(1);
         end
      end

      // address registers, frozen while a write runs
      // address locked busy
      if (wr_alow && !q.busy) begin
         nxt.addr[7:0] = I_IO_WDATA;
      end
      if (wr_ahigh && !q.busy) begin
         nxt.addr[ADDR_W-1:8] = I_IO_WDATA[ADDR_HIGH_BITS-1:0];
      end

      if (wr_data) begin
         nxt.data = I_IO_WDATA;
      end

      // control register write
      if (wr_ctrl) begin
         nxt.ready_ie = I_IO_WDATA[BIT_READY_IE];
         // a fresh one restarts the window
         if (I_IO_WDATA[BIT_WRITE_ARM]) begin
            nxt.arm_cnt = ARM_WINDOW;
         end else begin
            nxt.arm_cnt = 3'h0;
         end
      end

      if (start_wr) begin
         nxt.busy     = 1'b1;
         nxt.ticks    = '0;
         nxt.cap_addr = q.addr;
         nxt.cap_data = q.data;
         nxt.arm_cnt  = 3'h0;
         nxt.halt_cnt = WRITE_HALT;
      end

      // read lands in the data register the same cycle it is taken;
      // a data write in the same access loses, the read is the later effect
      // immediate read
      if (start_rd) begin
         nxt.data     = mem_rd;
         nxt.halt_cnt = READ_HALT;
      end

      // synchronous reset: control state to defaults
      if (I_SYS_RST) begin
         nxt.data     = RST_DATA;
         nxt.ready_ie = RST_READY_IE;
         nxt.arm_cnt  = 3'h0;
         nxt.halt_cnt = 3'h0;
         nxt.div_cnt  = '0;
         nxt.addr     = q.addr;
         // a running write survives reset; an unknown flag falls to idle
         // write survives reset
         if (q.busy == 1'b1) begin
            nxt.busy     = q.busy;
            nxt.ticks    = q.ticks;
            nxt.cap_addr = q.cap_addr;
            nxt.cap_data = q.cap_data;
         end else begin
            nxt.busy     = 1'b0;
            nxt.ticks    = '0;
            nxt.cap_addr = '0;
            nxt.cap_data = 8'h00;
         end
      end

      // registered outputs, taken from the next state so they line up
      nxt.halt = (nxt.halt_cnt != 3'h0);
      nxt.irq  = nxt.ready_ie && I_GLOBAL_IRQ_EN && !nxt.busy && !I_SYS_RST;

      // read-back mux; the reserved bits come back zero
      nxt.rdata = 8'h00;
      if (io_hit(I_IO_ADDR, IO_CONTROL, I_IO_RD)) begin
         nxt.rdata = ctrl_image(q);
      end else if (io_hit(I_IO_ADDR, IO_DATA_BYTE, I_IO_RD)) begin
         nxt.rdata = q.data;
      end else if (io_hit(I_IO_ADDR, IO_ADDR_LOW, I_IO_RD)) begin
         nxt.rdata = q.addr[7:0];
      end else if (io_hit(I_IO_ADDR, IO_ADDR_HIGH, I_IO_RD)) begin
         nxt.rdata = {6'h00, q.addr[ADDR_W-1:8]};
      end
   end

   //==========================================================
   // registers
   //==========================================================
   // single register stage for all state
   always_ff @(posedge I_CLK_SYS) begin
      q <= nxt;
   end

   // byte store; only the end of a timed write changes it
   // store at end
   always_ff @(posedge I_CLK_SYS) begin
      if (commit) begin
         mem[q.cap_addr] <= q.cap_data;
      end
   end

   assign O_IO_RDATA  = q.rdata;
   assign O_CPU_HALT  = q.halt;
   assign O_READY_IRQ = q.irq;

   //==========================================================
   // checks
   //==========================================================
   default clocking cb @(posedge I_CLK_SYS); endclocking
   default disable iff (I_SYS_RST);

   // bounds follow the parameters, so a shortened write is judged as well;
   // reset cycles are not counted, and the divider restart after one reset
   // may cost up to one more tick period (one reset per write assumed)
   localparam int unsigned BUSY_MIN = (WRITE_CYCLES - 1) * OSC_DIVIDE + 1;
   localparam int unsigned BUSY_MAX = (WRITE_CYCLES + 1) * OSC_DIVIDE - 1;

   int unsigned busy_len;              // non-reset system cycles spent busy, checks only
   always_ff @(posedge I_CLK_SYS) begin
      if (!q.busy) begin
         busy_len <= 0;
      end else if (!I_SYS_RST) begin
         busy_len <= busy_len + 1;
      end
   end

   sequence halt_two_s;
      O_CPU_HALT [*2] ##1 !O_CPU_HALT;
   endsequence

   sequence halt_four_s;
      O_CPU_HALT [*4] ##1 !O_CPU_HALT;
   endsequence

   arm_window_a: assert property ($rose(q.arm_cnt != 3'h0) |-> q.arm_cnt == 3'h4)
      else $error("arm window did not open at four");
   arm_count_a: assert property ((q.arm_cnt != 3'h0) && !wr_ctrl && !start_wr
                                 |=> q.arm_cnt == $past(q.arm_cnt) - 3'h1)
      else $error("arm window did not count down");
   strobe_no_arm_a: assert property (wr_ctrl && I_IO_WDATA[BIT_WRITE_STROBE] && (q.arm_cnt == 3'h0)
                                     && !q.busy |=> !q.busy)
      else $error("write started without arming");
   write_stall_a: assert property (start_wr |=> q.busy ##0 halt_two_s)
      else $error("write start stall not two cycles");
   read_stall_a: assert property (start_rd |=> halt_four_s)
      else $error("read stall not four cycles");
   read_data_a: assert property (start_rd |=> q.data == $past(mem_rd))
      else $error("read data not loaded");
   addr_frozen_a: assert property (q.busy |=> q.addr == $past(q.addr))
      else $error("address changed during write");
   ready_irq_a: assert property (O_READY_IRQ == ($past(I_GLOBAL_IRQ_EN) && q.ready_ie && !q.busy))
      else $error("ready request does not follow enable and idle");
   self_prog_a: assert property (wr_ctrl && I_SELF_PROG_ENABLE |=> !$rose(q.busy))
      else $error("write started during self-programming");
   busy_span_a: assert property ($fell(q.busy) |-> ($past(busy_len) + 1 >= BUSY_MIN)
                                 && ($past(busy_len) + 1 <= BUSY_MAX))
      else $error("write length out of range");
   arm_start_a: assert property (wr_ctrl && I_IO_WDATA[BIT_WRITE_STROBE] && (q.arm_cnt != 3'h0)
                                 && !q.busy && !I_SELF_PROG_ENABLE |=> q.busy && O_CPU_HALT)
      else $error("armed strobe did not start a write");
   ctrl_upper_a: assert property (io_hit(I_IO_ADDR, IO_CONTROL, I_IO_RD) |=> O_IO_RDATA[7:4] == 4'h0)
      else $error("reserved control bits read nonzero");
   rdata_idle_a: assert property (!I_IO_RD |=> O_IO_RDATA == 8'h00)
      else $error("read data seen without a read");

endmodule

`default_nettype wire

// *** inc/nvm_byte_pkg.sv ***
//==========================================================
// nvm byte access constants
//==========================================================
package nvm_byte_pkg;

   // geometry of the data store
   localparam int unsigned NVM_DEPTH = 1024;   // bytes in the store
   localparam int unsigned ADDR_W    = 10;     // linear byte index width
   localparam int unsigned DATA_W    = 8;      // byte width
   localparam int unsigned IO_ADDR_W = 6;      // processor i/o space index width

   // i/o space locations of the four registers
   localparam logic [5:0] IO_CONTROL   = 6'h1c;  // nvm_control
   localparam logic [5:0] IO_DATA_BYTE = 6'h1d;  // nvm_data_byte
   localparam logic [5:0] IO_ADDR_LOW  = 6'h1e;  // nvm_addr_low
   localparam logic [5:0] IO_ADDR_HIGH = 6'h1f;  // nvm_addr_high

   // nvm_control bit positions
   localparam int unsigned BIT_READ_STROBE  = 0;  // read_strobe
   localparam int unsigned BIT_WRITE_STROBE = 1;  // write_strobe
   localparam int unsigned BIT_WRITE_ARM    = 2;  // master_write_arm
   localparam int unsigned BIT_READY_IE     = 3;  // ready_irq_enable
   localparam int unsigned ADDR_HIGH_BITS   = 2;  // implemented bits of nvm_addr_high

   // reset values of control state
   localparam logic       RST_READY_IE = 1'b0;
   localparam logic [7:0] RST_DATA     = 8'h00;

   // cpu timing, in cycles of the cpu clock
   localparam logic [2:0] ARM_WINDOW  = 3'h4;  // arming lasts this many cycles
   localparam logic [2:0] WRITE_HALT  = 3'h2;  // stall after a write start
   localparam logic [2:0] READ_HALT   = 3'h4;  // stall after a read

   // write timing
   localparam int unsigned CLK_PERIOD_NS    = 10;    // system clock period
   localparam int unsigned OSC_PERIOD_NS    = 1000;  // calibrated oscillator period, 1 MHz
   localparam int unsigned OSC_DIV          = (OSC_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned WRITE_OSC_CYCLES = 8448;  // oscillator cycles per byte write
   localparam int unsigned WRITE_TIME_US    = 8500;  // typical write time, for reference
   localparam int unsigned DIV_W            = 7;     // divider counter width
   localparam int unsigned TICK_W           = 14;    // oscillator tick counter width

endpackage

// *** tb/nvm_byte_access_bench.sv ***
`timescale 1ns/100ps
`default_nettype none

module nvm_byte_access_bench;
   import nvm_byte_pkg::*;

   //==========================================================
   // bench signals
   //==========================================================
   // shortened write timing so one byte write takes a handful of cycles
   localparam int unsigned ODIV = 2;
   localparam int unsigned WCYC = 4;
   logic       clk;          // system clock
   logic       rst;          // synchronous reset
   logic [5:0] io_addr;      // i/o index of the access
   logic       io_wr;        // i/o write pulse
   logic       io_rd;        // i/o read pulse
   logic [7:0] wdata;        // i/o write data
   logic       gie;          // global interrupt enable
   logic       spe;          // flash self-programming busy
   logic [7:0] rdata;        // i/o read data
   logic       halt;         // cpu stall
   logic       irq;          // ready request
   int         miscompares;  // mismatches seen
   int         n_tests;      // comparisons made

   nvm_byte_access #(.DEPTH(NVM_DEPTH), .OSC_DIVIDE(ODIV), .WRITE_CYCLES(WCYC)) DUT (
      .I_CLK_SYS          (clk),
      .I_SYS_RST          (rst),
      .I_IO_ADDR          (io_addr),
      .I_IO_WR            (io_wr),
      .I_IO_RD            (io_rd),
      .I_IO_WDATA         (wdata),
      .I_GLOBAL_IRQ_EN    (gie),
      .I_SELF_PROG_ENABLE (spe),
      .O_IO_RDATA         (rdata),
      .O_CPU_HALT         (halt),
      .O_READY_IRQ        (irq)
   );

   //==========================================================
   // bus tasks; each is entered and left 1 ns after a rising edge
   //==========================================================
   task chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      n_tests++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD %s expected %h seen %h", name, exp, got);
      end
   endtask

   // idling releases both strobes, once per time step
   task idle(input int n);
      io_wr = 1'b0;
      io_rd = 1'b0;
      repeat (n) begin
         @(posedge clk);
         #1;
      end
   endtask

   // write taken at the next edge; the strobe is left up and is lowered by
   // whichever task drives next, so no strobe is assigned twice in one step
   task wr(input logic [5:0] a, input logic [7:0] d);
      io_addr = a;
      wdata   = d;
      io_rd   = 1'b0;
      io_wr   = 1'b1;
      @(posedge clk);
      #1;
   endtask

   // read data is registered, so it is settled just after the taking edge
   task rd(input logic [5:0] a, output logic [7:0] d);
      io_addr = a;
      io_wr   = 1'b0;
      io_rd   = 1'b1;
      @(posedge clk);
      #1;
      d       = rdata;
   endtask

   task set_addr(input logic [9:0] a);
      wr(IO_ADDR_HIGH, {6'h00, a[9:8]});
      wr(IO_ADDR_LOW, a[7:0]);
   endtask

   // stall lasts two cycles after an accepted strobe, none when refused
   task strobe_chk(input logic go);
      for (int i = 0; i < 3; i++) begin
         chk("write halt", {7'h00, go & (i < 2)}, {7'h00, halt});
         idle(1);
      end
   endtask

   task start_write(input logic [9:0] a, input logic [7:0] d, input logic [7:0] ie, input logic go);
      set_addr(a);
      wr(IO_DATA_BYTE, d);
      wr(IO_CONTROL, 8'h04 | ie);
      wr(IO_CONTROL, 8'h06 | ie);
      strobe_chk(go);
   endtask

   // polls the busy bit; a bounded loop so a stuck write cannot hang the run
   task wait_idle(output int cyc);
      logic [7:0] c;
      cyc = 0;
      c   = 8'h02;
      while (c[1] !== 1'b0 && cyc < 1000) begin
         rd(IO_CONTROL, c);
         cyc++;
      end
   endtask

   task read_byte(input logic [9:0] a, output logic [7:0] d);
      int cyc;
      wait_idle(cyc);
      set_addr(a);
      wr(IO_CONTROL, 8'h01);
      for (int i = 0; i < 5; i++) begin
         chk("read halt", {7'h00, i < 4}, {7'h00, halt});
         idle(1);
      end
      rd(IO_DATA_BYTE, d);
   endtask

   //==========================================================
   // scenarios
   //==========================================================
   task t_regs;
      logic [7:0] v;
      wr(IO_CONTROL, 8'hf0);
      rd(IO_CONTROL, v);
      chk("control idle", 8'h00, v);
      rd(6'h00, v);
      chk("unmapped", 8'h00, v);
      rd(IO_DATA_BYTE, v);
      chk("data reset", RST_DATA, v);
      wr(IO_ADDR_HIGH, 8'hff);
      rd(IO_ADDR_HIGH, v);
      chk("addr high", 8'h03, v);
      wr(IO_ADDR_LOW, 8'ha5);
      rd(IO_ADDR_LOW, v);
      chk("addr low", 8'ha5, v);
   endtask

   // boundary addresses, write timing and the ready request
   task t_write_read;
      static logic [9:0] al [3] = '{10'h000, 10'h3ff, 10'h2aa};
      static logic [7:0] dl [3] = '{8'h3c, 8'hc3, 8'h96};
      logic [7:0]        v;
      int                cyc;
      gie = 1'b1;
      for (int i = 0; i < 3; i++) begin
         start_write(al[i], dl[i], 8'h08, 1'b1);
         chk("irq busy", 8'h00, {7'h00, irq});
         wait_idle(cyc);
         chk("busy span", 8'h01, {7'h00, cyc >= (WCYC - 1) * ODIV - 1 && cyc <= WCYC * ODIV - 2});
         idle(1);
         chk("irq idle", 8'h01, {7'h00, irq});
         gie = 1'b0;
         idle(2);
         chk("irq masked", 8'h00, {7'h00, irq});
         gie = 1'b1;
      end
      for (int i = 0; i < 3; i++) begin
         read_byte(al[i], v);
         chk("readback", dl[i], v);
      end
      gie = 1'b0;
   endtask

   // arming self-clears; late or unarmed strobes program nothing
   task t_arm;
      logic [7:0] v;
      set_addr(10'h000);
      wr(IO_DATA_BYTE, 8'h77);
      wr(IO_CONTROL, 8'h04);
      rd(IO_CONTROL, v);
      chk("arm set", 8'h04, v);
      idle(3);
      wr(IO_CONTROL, 8'h02);
      strobe_chk(1'b0);
      rd(IO_CONTROL, v);
      chk("arm cleared", 8'h00, v);
      wr(IO_CONTROL, 8'h02);
      strobe_chk(1'b0);
      // arm and strobe in one write must not start either
      wr(IO_CONTROL, 8'h06);
      strobe_chk(1'b0);
      read_byte(10'h000, v);
      chk("no write", 8'h3c, v);
   endtask

   task t_selfprog;
      logic [7:0] v;
      spe = 1'b1;
      start_write(10'h3ff, 8'h11, 8'h00, 1'b0);
      rd(IO_CONTROL, v);
      chk("busy blocked", 8'h00, {7'h00, v[1]});
      spe = 1'b0;
      read_byte(10'h3ff, v);
      chk("flash lock", 8'hc3, v);
   endtask

   // address and read are refused while busy; the captured byte is stored
   task t_busy;
      logic [7:0] v;
      int         cyc;
      start_write(10'h000, 8'he1, 8'h00, 1'b1);
      wr(IO_ADDR_LOW, 8'h55);
      wr(IO_DATA_BYTE, 8'h1e);
      wr(IO_CONTROL, 8'h01);
      chk("read refused", 8'h00, {7'h00, halt});
      rd(IO_ADDR_LOW, v);
      chk("addr frozen", 8'h00, v);
      wait_idle(cyc);
      read_byte(10'h000, v);
      chk("captured", 8'he1, v);
   endtask

   // a reset in mid-write leaves the write running to the end
   task t_reset;
      logic [7:0] v;
      int         cyc;
      start_write(10'h2aa, 8'h0f, 8'h08, 1'b1);
      rst = 1'b1;
      idle(2);
      rst = 1'b0;
      rd(IO_CONTROL, v);
      chk("busy kept", 8'h02, v);
      wait_idle(cyc);
      read_byte(10'h2aa, v);
      chk("write kept", 8'h0f, v);
   endtask

   //==========================================================
   // run control
   //==========================================================
   task stop_test;
      $display("comparisons %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // free-running clock, 10 ns period
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // the whole run needs well under a thousand cycles
   initial begin
      #200000;
      miscompares++;
      stop_test;
   end

   // main sequence
   initial begin
      miscompares = 0;
      n_tests     = 0;
      rst         = 1'b1;
      io_addr     = 6'h00;
      io_wr       = 1'b0;
      io_rd       = 1'b0;
      wdata       = 8'h00;
      gie         = 1'b0;
      spe         = 1'b0;
      repeat (2) @(posedge clk);
      #1;
      rst = 1'b0;
      t_regs;
      t_write_read;
      t_arm;
      t_selfprog;
      t_busy;
      t_reset;
      stop_test;
   end
endmodule

`default_nettype wire
